// ==== core/cvr_pkg.sv ====
// Package with register map, field layout and shared types of the comparator and reference control block.
package cvr_pkg;

    // Register offsets on the plain register port.
    localparam logic [7:0] CORE_INTERRUPT_CONTROL_ADDR = 8'h0B;
    localparam logic [7:0] PERIPHERAL_IRQ_FLAGS_ADDR = 8'h0C;
    localparam logic [7:0] COMPARATOR_CONTROL_ADDR = 8'h1F;
    localparam logic [7:0] PORT_A_DIRECTION_ADDR = 8'h85;
    localparam logic [7:0] PERIPHERAL_IRQ_ENABLES_ADDR = 8'h8C;
    localparam logic [7:0] REFERENCE_LADDER_CONTROL_ADDR = 8'h9F;

    // Field positions.
    localparam int GLOBAL_IRQ_ENABLE_BIT = 7;
    localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
    localparam int COMPARATOR_CHANGE_FLAG_BIT = 6;
    localparam int COMPARATOR_IRQ_ENABLE_BIT = 6;
    localparam int SECOND_COMP_OUT_BIT = 7;
    localparam int FIRST_COMP_OUT_BIT = 6;
    localparam int INPUT_SWITCH_BIT = 3;
    localparam int REFERENCE_ENABLE_BIT = 7;
    localparam int REFERENCE_PIN_OE_BIT = 6;
    localparam int REFERENCE_RANGE_BIT = 5;
    localparam int REF_OUT_DIR_BIT = 2;
    localparam int FIRST_COMP_PIN_DIR_BIT = 3;
    localparam int SECOND_COMP_PIN_DIR_BIT = 4;

    // Writable masks and reset values.
    localparam logic [7:0] CORE_INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [7:0] COMPARATOR_CONTROL_WMASK = 8'h0F;
    localparam logic [7:0] REFERENCE_LADDER_CONTROL_WMASK = 8'hEF;
    localparam logic [7:0] PORT_A_DIRECTION_WMASK = 8'h1F;
    localparam logic [7:0] PORT_A_DIRECTION_RESET = 8'h1F;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [2:0] {
        CVR_MODE_RESET = 3'b000,
        CVR_MODE_INTERNAL_REF = 3'b010,
        CVR_MODE_PIN_OUTPUTS = 3'b110,
        CVR_MODE_OFF = 3'b111
    } cvr_mode_e;

    // Reference ladder steering towards the analog part.
    typedef struct packed {
        logic ladderPowered;
        logic rangeLow;
        logic [3:0] tapValue;
        logic pinConnect;
        logic toComparators;
    } cvr_ladder_s;

    // Comparator steering towards the analog part.
    typedef struct packed {
        logic powered;
        logic [2:0] modeCode;
        logic inputSwitch;
        logic internalRefPlus;
    } cvr_comp_s;

endpackage : cvr_pkg

// ==== core/cvr_comparator_vref_control.sv ====
// Digital control of the dual comparator, its change flag and the reference ladder.
//
// Added by the designer: the address-and-strobe port.

// Notes on behaviour
// - Change flag sets whenever either comparator output changes outside a read or write of comparator control.
// - Change flag sits at bit 6 of the peripheral flag register.
// - Writing zero clears the flag; writing one sets it for a simulated interrupt.
// - Interrupt request needs comparator, peripheral and global enables all set.
// - Flag still sets while any enable is clear.
// - A change coinciding with a control read may miss setting the flag.
// - Any read or write of comparator control ends the mismatch.
// - A persisting mismatch keeps setting the flag; after a read, clearing sticks.
// - Comparator outputs read in bits 7 and 6 of comparator control.
// - Comparators and their interrupt stay active in sleep and wake the core.
// - Mode code 111 powers both comparators off.
// - Waking from sleep leaves comparator control unchanged.
// - Reset returns comparator control to zero, mode 000.
// - Comparators are powered down throughout reset.
// - Ladder is powered down while reference enable is clear.
// - Reset clears reference enable, pin enable, range and tap value.
// - Waking from sleep leaves reference control unchanged.
// - Reference reaches its pin only with direction bit 2 and pin enable set.
// - Reference controls are independent of the comparator mode.
// - Mode 010 applies the internal reference to both non-inverting inputs.
// - Mode 110 drives raw comparator outputs to pins, gated by direction bits.
// - Comparator output bits are read-only.
module cvr_comparator_vref_control
    import cvr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [7:0] regRdData,
    input wire logic firstComparatorRaw,
    input wire logic secondComparatorRaw,
    input wire logic sleepActive,
    output logic irqRequest,
    output logic wakeRequest,
    output cvr_comp_s compCtrl,
    output cvr_ladder_s ladderCtrl,
    output logic firstCompPinData,
    output logic firstCompPinOe,
    output logic secondCompPinData,
    output logic secondCompPinOe
);

    logic [7:0] coreIrqCtrl_r;
    logic [7:0] irqFlags_r;
    logic [7:0] compCtrl_r;
    logic [7:0] portDir_r;
    logic [7:0] irqEnables_r;
    logic [7:0] ladderCtrl_r;
    logic [1:0] sync1_r;
    logic [1:0] sync2_r;
    logic [1:0] sync3_r;
    logic [1:0] compOut_r;
    logic [1:0] seenOut_r;
    logic mismatch;
    logic compAccess;
    logic flagWrite;
    logic [7:0] regRdData_nxt;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        hit = (addr == target);
    endfunction : hit

    // Mode decoding is needed by the steering and by the pin multiplexer alike.
    function automatic logic modeIs(input logic [7:0] ctrl, input cvr_mode_e mode);
        modeIs = (ctrl[2:0] == mode);
    endfunction : modeIs

    assign compAccess = (regWrStrobe || regRdStrobe) && hit(regAddr, COMPARATOR_CONTROL_ADDR);
    assign flagWrite = regWrStrobe && hit(regAddr, PERIPHERAL_IRQ_FLAGS_ADDR);

    // Three stages per output; a change counts once stages two and three agree.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : gSync
            logic rawIn;
            assign rawIn = (gi == 0) ? firstComparatorRaw : secondComparatorRaw;
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    compOut_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= rawIn;
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        compOut_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // Powered-off comparators hold their outputs low, so no change is seen then.
    assign mismatch = (compOut_r != seenOut_r);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            seenOut_r <= 2'h0;
        end else if (compAccess) begin
            seenOut_r <= compOut_r;
        end
    end

    // The flag sees the mismatch regardless of enables; the set wins over a clearing write.
    // A change landing on a control access is folded into the latch and so may go unflagged.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqFlags_r <= REG_RESET;
        end else if (mismatch && !compAccess) begin
            irqFlags_r[COMPARATOR_CHANGE_FLAG_BIT] <= 1'b1;
        end else if (flagWrite) begin
            irqFlags_r[COMPARATOR_CHANGE_FLAG_BIT] <= regWrData[COMPARATOR_CHANGE_FLAG_BIT];
        end
    end

    // Sleep has no path into any of the registers below, so waking leaves them as they were.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            compCtrl_r <= REG_RESET;
        end else if (regWrStrobe && hit(regAddr, COMPARATOR_CONTROL_ADDR)) begin
            compCtrl_r <= regWrData & COMPARATOR_CONTROL_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ladderCtrl_r <= REG_RESET;
        end else if (regWrStrobe && hit(regAddr, REFERENCE_LADDER_CONTROL_ADDR)) begin
            ladderCtrl_r <= regWrData & REFERENCE_LADDER_CONTROL_WMASK;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            coreIrqCtrl_r <= CORE_INTERRUPT_CONTROL_RESET;
        end else if (regWrStrobe && hit(regAddr, CORE_INTERRUPT_CONTROL_ADDR)) begin
            coreIrqCtrl_r <= regWrData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            irqEnables_r <= REG_RESET;
        end else if (regWrStrobe && hit(regAddr, PERIPHERAL_IRQ_ENABLES_ADDR)) begin
            irqEnables_r[COMPARATOR_IRQ_ENABLE_BIT] <= regWrData[COMPARATOR_IRQ_ENABLE_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            portDir_r <= PORT_A_DIRECTION_RESET;
        end else if (regWrStrobe && hit(regAddr, PORT_A_DIRECTION_ADDR)) begin
            portDir_r <= regWrData & PORT_A_DIRECTION_WMASK;
        end
    end

    // Read data stand in the cycle after the strobe; the outputs read live.
    always_comb begin
        regRdData_nxt = 8'h00;
        case (regAddr)
            COMPARATOR_CONTROL_ADDR: begin
                regRdData_nxt = compCtrl_r;
                regRdData_nxt[SECOND_COMP_OUT_BIT] = compOut_r[1];
                regRdData_nxt[FIRST_COMP_OUT_BIT] = compOut_r[0];
            end
            REFERENCE_LADDER_CONTROL_ADDR: regRdData_nxt = ladderCtrl_r;
            CORE_INTERRUPT_CONTROL_ADDR: regRdData_nxt = coreIrqCtrl_r;
            PERIPHERAL_IRQ_FLAGS_ADDR: regRdData_nxt = irqFlags_r;
            PERIPHERAL_IRQ_ENABLES_ADDR: regRdData_nxt = irqEnables_r;
            PORT_A_DIRECTION_ADDR: regRdData_nxt = portDir_r;
            default: regRdData_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            regRdData <= 8'h00;
        end else if (regRdStrobe) begin
            regRdData <= regRdData_nxt;
        end else begin
            regRdData <= 8'h00;
        end
    end

    always_comb begin
        irqRequest = irqFlags_r[COMPARATOR_CHANGE_FLAG_BIT] && irqEnables_r[COMPARATOR_IRQ_ENABLE_BIT]
            && coreIrqCtrl_r[PERIPHERAL_IRQ_ENABLE_BIT] && coreIrqCtrl_r[GLOBAL_IRQ_ENABLE_BIT];
        // Wake does not need the global enable, as the core resumes either way.
        wakeRequest = sleepActive && irqFlags_r[COMPARATOR_CHANGE_FLAG_BIT]
            && irqEnables_r[COMPARATOR_IRQ_ENABLE_BIT] && coreIrqCtrl_r[PERIPHERAL_IRQ_ENABLE_BIT];
    end

    always_comb begin
        compCtrl.modeCode = compCtrl_r[2:0];
        compCtrl.inputSwitch = compCtrl_r[INPUT_SWITCH_BIT];
        compCtrl.powered = !sys_rst && !modeIs(compCtrl_r, CVR_MODE_OFF);
        compCtrl.internalRefPlus = modeIs(compCtrl_r, CVR_MODE_INTERNAL_REF);
        ladderCtrl.ladderPowered = ladderCtrl_r[REFERENCE_ENABLE_BIT];
        ladderCtrl.rangeLow = ladderCtrl_r[REFERENCE_RANGE_BIT];
        ladderCtrl.tapValue = ladderCtrl_r[3:0];
        ladderCtrl.pinConnect = ladderCtrl_r[REFERENCE_PIN_OE_BIT] && portDir_r[REF_OUT_DIR_BIT];
        ladderCtrl.toComparators = modeIs(compCtrl_r, CVR_MODE_INTERNAL_REF);
    end

    // Mode 110 uses the raw, unsynchronised outputs; direction bit clear means drive.
    always_comb begin
        firstCompPinData = firstComparatorRaw;
        secondCompPinData = secondComparatorRaw;
        firstCompPinOe = modeIs(compCtrl_r, CVR_MODE_PIN_OUTPUTS) && !portDir_r[FIRST_COMP_PIN_DIR_BIT];
        secondCompPinOe = modeIs(compCtrl_r, CVR_MODE_PIN_OUTPUTS) && !portDir_r[SECOND_COMP_PIN_DIR_BIT];
    end

endmodule : cvr_comparator_vref_control

// ==== testbench/cvr_control_props.sv ====
// Port-level checker for the comparator and reference control block.
module cvr_control_props
    import cvr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic regRdStrobe,
    input wire logic [7:0] regRdData,
    input wire logic firstComparatorRaw,
    input wire logic sleepActive,
    input wire logic irqRequest,
    input wire logic wakeRequest,
    input wire cvr_comp_s compCtrl,
    input wire cvr_ladder_s ladderCtrl,
    input wire logic firstCompPinData,
    input wire logic firstCompPinOe
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // The first edge after release shows the reset values, and the comparators were off during reset.
    a_reset_quiet: assert property ($fell(sys_rst) |-> $past(!compCtrl.powered) &&
        compCtrl.modeCode == 3'b000 && !ladderCtrl.ladderPowered && !ladderCtrl.rangeLow &&
        ladderCtrl.tapValue == 4'h0 && !ladderCtrl.pinConnect)
        else $error("block not quiet after reset");
    a_mode_off: assert property (compCtrl.modeCode == 3'b111 |-> !compCtrl.powered)
        else $error("comparators powered in off mode");
    a_internal_ref: assert property (compCtrl.internalRefPlus == (compCtrl.modeCode == 3'b010))
        else $error("internal reference steering wrong");
    a_pin_mux: assert property (firstCompPinOe |-> compCtrl.modeCode == 3'b110 &&
        firstCompPinData == firstComparatorRaw)
        else $error("comparator pin driven outside output mode");
    a_irq_wake: assert property (irqRequest && sleepActive |-> wakeRequest)
        else $error("enabled change did not wake");
    a_wake_sleep: assert property (wakeRequest |-> sleepActive)
        else $error("wake raised while awake");
    a_flag_layout: assert property (regRdStrobe && regAddr == 8'h0C |=> (regRdData & 8'hBF) == 8'h00)
        else $error("flag register shows bits other than the flag");
    a_ctrl_layout: assert property (regRdStrobe && regAddr == 8'h1F |=> regRdData[5:4] == 2'b00)
        else $error("control register unused bits not zero");

    c_irq: cover property (irqRequest);
    c_wake: cover property (wakeRequest);
    c_pin_out: cover property (firstCompPinOe);
endmodule : cvr_control_props

bind cvr_comparator_vref_control cvr_control_props u_props (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .regAddr(regAddr), .regRdStrobe(regRdStrobe), .regRdData(regRdData), .firstComparatorRaw(firstComparatorRaw),
    .sleepActive(sleepActive), .irqRequest(irqRequest), .wakeRequest(wakeRequest), .compCtrl(compCtrl),
    .ladderCtrl(ladderCtrl), .firstCompPinData(firstCompPinData), .firstCompPinOe(firstCompPinOe));

// ==== testbench/cvr_comparator_vref_control_test.sv ====
// Self-checking bench for the comparator and reference control block.
module cvr_comparator_vref_control_test
    import cvr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk = 1'b0;
    logic sys_rst, regWrStrobe, regRdStrobe, firstRaw, secondRaw, sleepActive, irqRequest, wakeRequest;
    logic firstPinData, secondPinData, firstPinOe, secondPinOe;
    logic [7:0] regAddr, regWrData, regRdData, rdVal;
    cvr_comp_s compCtrl;
    cvr_ladder_s ladderCtrl;
    int errors = 0;
    int testsRun = 0;
    int waitCount;
    // Ordinary register cases: address, written value, value read back.
    logic [7:0] rowAddr[8] = '{8'h8C, 8'h9F, 8'h85, 8'h1F, 8'h0C, 8'h0C, 8'h30, 8'h1F};
    logic [7:0] rowData[8] = '{8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'h40, 8'h00, 8'hFF, 8'h02};
    logic [7:0] rowExp[8] = '{8'h40, 8'hEF, 8'h1F, 8'h07, 8'h40, 8'h00, 8'h00, 8'h02};
    logic [7:0] rstAddr[6] = '{8'h0B, 8'h0C, 8'h1F, 8'h85, 8'h8C, 8'h9F};
    logic [7:0] rstExp[6] = '{8'h00, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00};

    cvr_comparator_vref_control dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
        .firstComparatorRaw(firstRaw), .secondComparatorRaw(secondRaw), .sleepActive(sleepActive),
        .irqRequest(irqRequest), .wakeRequest(wakeRequest), .compCtrl(compCtrl), .ladderCtrl(ladderCtrl),
        .firstCompPinData(firstPinData), .firstCompPinOe(firstPinOe), .secondCompPinData(secondPinData),
        .secondCompPinOe(secondPinOe));

    always #5 sys_clk = ~sys_clk;

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Each access leaves one idle cycle, so a strobe is never raised and lowered in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge sys_clk);
        regWrStrobe <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge sys_clk);
        regRdStrobe <= 1'b0;
        #1 d = regRdData;
    endtask : rd

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", testsRun, errors);
        if (errors == 0 && testsRun > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : complete_run

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        complete_run();
    end

    initial begin
        {sys_rst, regWrStrobe, regRdStrobe, firstRaw, secondRaw, sleepActive} <= 6'b100000;
        regAddr <= 8'h00;
        regWrData <= 8'h00;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wr(rowAddr[i], rowData[i]);
            rd(rowAddr[i], rdVal);
            chk(rdVal, rowExp[i]);
        end
        $display("register table test done");
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({7'h00, compCtrl.powered}, 8'h00);
        sys_rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(rstAddr[i], rdVal);
            chk(rdVal, rstExp[i]);
        end
        $display("reset value test done");
        // A change with every enable clear still raises the flag but no request.
        @(posedge sys_clk);
        firstRaw <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rd(8'h0C, rdVal);
        chk(rdVal, 8'h40);
        chk({7'h00, irqRequest}, 8'h00);
        // Without a control access the mismatch persists, so a clearing write does not stick.
        wr(8'h0C, 8'h00);
        rd(8'h0C, rdVal);
        chk(rdVal, 8'h40);
        rd(8'h1F, rdVal);
        chk(rdVal, 8'h40);
        wr(8'h0C, 8'h00);
        repeat (4) @(posedge sys_clk);
        rd(8'h0C, rdVal);
        chk(rdVal, 8'h00);
        $display("change flag test done");
        wr(8'h8C, 8'h40);
        wr(8'h0B, 8'hC0);
        sleepActive <= 1'b1;
        secondRaw <= 1'b1;
        waitCount = 0;
        while (irqRequest !== 1'b1 && waitCount < 20) begin
            @(posedge sys_clk);
            waitCount++;
        end
        if (waitCount >= 20) errors++;
        chk({6'h00, irqRequest, wakeRequest}, 8'h03);
        rd(8'h1F, rdVal);
        chk(rdVal, 8'hC0);
        wr(8'h0C, 8'h00);
        #1 chk({7'h00, irqRequest}, 8'h00);
        $display("interrupt and wake test done");
        wr(8'h1F, 8'h06);
        wr(8'h85, 8'h07);
        #1 chk({4'h0, firstPinData, secondPinData, firstPinOe, secondPinOe}, 8'h0F);
        wr(8'h9F, 8'hC5);
        #1 chk(ladderCtrl, 8'h96);
        wr(8'h85, 8'h03);
        #1 chk({7'h00, ladderCtrl.pinConnect}, 8'h00);
        // Internal reference mode with the input switch set; the ladder keeps its own settings.
        wr(8'h1F, 8'h0A);
        #1 chk({2'b00, compCtrl}, 8'h2B);
        chk(ladderCtrl, 8'h95);
        chk({7'h00, firstPinOe}, 8'h00);
        @(posedge sys_clk);
        sleepActive <= 1'b0;
        rd(8'h9F, rdVal);
        chk(rdVal, 8'hC5);
        rd(8'h1F, rdVal);
        chk(rdVal, 8'hCA);
        $display("pin and ladder test done");
        complete_run();
    end
endmodule : cvr_comparator_vref_control_test
